// >>> logic/lp_clock_ctrl.sv
// Low-power mode and clock control with AHB-Lite register access.
// Assumes one hclk domain; gating outputs feed clock enables elsewhere.
//
// Overview of operation
// - Seven operating modes exist: PLL clock, PLL sleep, timer, main clock, main sleep, stop and hardware standby.
// - Every mode other than PLL clock counts as a low-power mode.
// - Main clock and main sleep run from the main oscillator with the PLL stopped.
// - With the PLL stopped the operating clock is the main oscillator divided by two.
// - Both sleep modes gate only the CPU clock; peripherals keep theirs.
// - Timer mode stops every clock except the one of the timebase timer.
// - Stop and hardware standby halt the oscillator but keep all stored contents.
// - With intermittent operation on, CPU accesses get a throttled CPU clock.
// - Peripherals keep the full-speed clock while the CPU is throttled.
// - A two-bit ratio field sets the PLL multiplier to one, two, three or four.
// - A two-bit settle field picks the oscillator wait after stop or hardware standby.
// - The timebase timer always runs from the main oscillator clock.
// - The timebase is an 18-bit counter with interval ticks whose carry clocks the watchdog.
// - The low-power mode control register is 8 bits at index 0xa0, reset 0x18.
// - The clock source select register is 8 bits at index 0xa1, reset 0xfc.
`timescale 1ns/1ns
`default_nettype none
module lp_clock_ctrl
  import lpcc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC0 = 1024,
  parameter int unsigned SETTLE_CYC1 = 8192,
  parameter int unsigned SETTLE_CYC2 = 32768,
  parameter int unsigned SETTLE_CYC3 = 131072
)
(
  input wire logic hclk, // main oscillator clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  input wire logic wake_req, // pending interrupt, wakes sleep, timer and stop modes
  input wire logic hw_standby_n, // standby pin, active low
  input wire logic cpu_access, // CPU access in progress
  output logic cpu_clk_en, // CPU clock enable
  output logic periph_clk_en, // peripheral clock enable
  output logic tbt_run, // timebase clock enable
  output logic osc_en, // oscillator enable
  output logic pll_en, // PLL enable
  output logic main_div2, // system clock is main oscillator / 2
  output logic [2:0] pll_ratio, // PLL multiplier, 1 to 4
  output logic low_power, // any mode but PLL clock
  output logic pins_hiz, // pins float in deep modes
  output logic sw_reset, // one-cycle software reset request
  output logic wdt_clk, // timebase carry to watchdog
  output logic irq // level interrupt
);

  typedef struct packed {
    mode_t mode;
    logic pin_state;
    logic [1:0] cg;
    logic [1:0] ws;
    logic main_clock_select;
    logic [1:0] cs;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [4:0] int_cnt;
    logic dp_wr;
    logic [31:0] dp_addr;
    logic [31:0] hrdata;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic tbt_run;
    logic osc_en;
    logic pll_en;
    logic main_div2;
    logic [2:0] pll_ratio;
    logic low_power;
    logic pins_hiz;
    logic sw_reset;
    logic irq;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic tbt_carry;
  logic tbt_tick;

  // Timebase counts on hclk, the main oscillator, whatever mcs selects
  timebase_counter u_tbt (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(s_reg.tbt_run),
    .carry(tbt_carry),
    .tick(tbt_tick)
  );

  function automatic logic is_run(input mode_t m);
    return (m == MODE_PLL_CLOCK) || (m == MODE_MAIN_CLOCK);
  endfunction

  function automatic logic is_awake(input mode_t m);
    return is_run(m) || (m == MODE_PLL_SLEEP) || (m == MODE_MAIN_SLEEP);
  endfunction

  logic addr_phase;
  logic lpmc_wr;
  logic css_wr;
  logic [7:0] wd;
  logic [IRQ_W-1:0] rd_clr;
  logic [IRQ_W-1:0] events;
  logic [4:0] div;
  logic throttle;
  mode_t run_mode;
  logic [7:0] lpmc_rd;
  logic [7:0] css_rd;

  always_comb begin
    s_next = s_reg;
    wd = hwdata[7:0];
    addr_phase = hsel && htrans[1] && hready;
    lpmc_wr = s_reg.dp_wr && (s_reg.dp_addr == LPMC_ADDR);
    css_wr = s_reg.dp_wr && (s_reg.dp_addr == CSS_ADDR);
    events = '0;
    rd_clr = '0;
    run_mode = s_reg.main_clock_select ? MODE_MAIN_CLOCK : MODE_PLL_CLOCK;
    // Write-only and reserved bits read back at their fixed levels
    lpmc_rd = {2'b00, s_reg.pin_state, 2'b11, s_reg.cg, 1'b0};
    css_rd = {1'b1, ~(s_reg.mode == MODE_PLL_CLOCK ||
                      s_reg.mode == MODE_PLL_SLEEP),
              s_reg.ws, 1'b1, s_reg.main_clock_select, s_reg.cs};

    // Address phase: capture, and build read data ahead of the data phase
    s_next.dp_wr = addr_phase && hwrite && (hsize == HSIZE_WORD);
    if (addr_phase) begin
      s_next.dp_addr = haddr;
    end
    if (addr_phase && !hwrite) begin
      case (haddr)
        LPMC_ADDR: s_next.hrdata = {24'h0, lpmc_rd};
        CSS_ADDR: s_next.hrdata = {24'h0, css_rd};
        IRQ_STATUS_ADDR: begin
          s_next.hrdata = {29'h0, s_reg.status};
          rd_clr = s_reg.status;
        end
        IRQ_MASK_ADDR: s_next.hrdata = {29'h0, s_reg.mask};
        MODE_STATUS_ADDR: s_next.hrdata = {29'h0, s_reg.mode};
        default: s_next.hrdata = 32'h0;
      endcase
    end

    // Data phase writes
    s_next.sw_reset = lpmc_wr && !wd[SW_RESET_POS];
    if (lpmc_wr) begin
      s_next.pin_state = wd[PIN_STATE_POS];
      s_next.cg = wd[INTERMIT_SEL_LO+:2];
    end
    if (css_wr) begin
      s_next.ws = wd[SETTLE_SEL_LO+:2];
      s_next.main_clock_select = wd[MAIN_SEL_POS];
      s_next.cs = wd[PLL_RATIO_LO+:2];
    end
    if (s_reg.dp_wr && (s_reg.dp_addr == IRQ_MASK_ADDR)) begin
      s_next.mask = hwdata[IRQ_W-1:0];
    end

    // Mode sequencing; standby pin overrides everything
    s_next.settle_cnt = s_reg.settle_cnt - 18'h00001;
    case (s_reg.mode)
      MODE_PLL_CLOCK, MODE_MAIN_CLOCK: begin
        if (lpmc_wr && wd[STOP_ENTRY_POS] && wd[SLEEP_ENTRY_POS]) begin
          s_next.mode = MODE_TIMER;
        end else if (lpmc_wr && wd[STOP_ENTRY_POS]) begin
          s_next.mode = MODE_STOP;
        end else if (lpmc_wr && wd[SLEEP_ENTRY_POS]) begin
          s_next.mode = (s_reg.mode == MODE_PLL_CLOCK) ?
                        MODE_PLL_SLEEP : MODE_MAIN_SLEEP;
        end else begin
          s_next.mode = run_mode;
        end
      end
      MODE_PLL_SLEEP: begin
        if (wake_req) begin
          s_next.mode = MODE_PLL_CLOCK;
        end
      end
      MODE_MAIN_SLEEP: begin
        if (wake_req) begin
          s_next.mode = MODE_MAIN_CLOCK;
        end
      end
      MODE_TIMER: begin
        if (wake_req) begin
          s_next.mode = run_mode;
        end
      end
      MODE_STOP: begin
        if (wake_req) begin
          s_next.mode = MODE_SETTLE;
        end
      end
      MODE_HW_STANDBY: begin
        s_next.mode = MODE_SETTLE;
      end
      MODE_SETTLE: begin
        if (s_reg.settle_cnt == '0) begin
          s_next.mode = run_mode;
          events[IRQ_WAKE_POS] = 1'b1;
        end
      end
      default: s_next.mode = run_mode;
    endcase
    if (!hw_standby_n) begin
      s_next.mode = MODE_HW_STANDBY;
    end
    // Settle count is reloaded in every mode but settle, and on entering standby
    if (s_next.mode == MODE_STOP || s_next.mode == MODE_HW_STANDBY ||
        s_reg.mode != MODE_SETTLE) begin
      case (s_next.ws)
        2'b00: s_next.settle_cnt = SETTLE_W'(SETTLE_CYC0 - 1);
        2'b01: s_next.settle_cnt = SETTLE_W'(SETTLE_CYC1 - 1);
        2'b10: s_next.settle_cnt = SETTLE_W'(SETTLE_CYC2 - 1);
        default: s_next.settle_cnt = SETTLE_W'(SETTLE_CYC3 - 1);
      endcase
    end
    events[IRQ_LP_POS] = is_run(s_reg.mode) && !is_run(s_next.mode) &&
                         (s_next.mode != MODE_SETTLE);
    events[IRQ_TICK_POS] = tbt_tick;

    // Intermittent CPU clock: one enabled cycle per div during accesses
    case (s_reg.cg)
      2'b01: div = INTERMIT_DIV1;
      2'b10: div = INTERMIT_DIV2;
      default: div = INTERMIT_DIV3;
    endcase
    throttle = (s_reg.cg != 2'b00) && cpu_access && is_run(s_reg.mode);
    if (throttle) begin
      s_next.int_cnt = (s_reg.int_cnt == div - 5'h01) ? 5'h00 :
                       s_reg.int_cnt + 5'h01;
    end else begin
      s_next.int_cnt = 5'h00;
    end

    // Gating outputs follow the mode being entered
    s_next.cpu_clk_en = is_run(s_next.mode) &&
                        (!throttle || s_reg.int_cnt == 5'h00);
    s_next.periph_clk_en = is_awake(s_next.mode);
    s_next.tbt_run = is_awake(s_next.mode) ||
                     (s_next.mode == MODE_TIMER);
    s_next.osc_en = (s_next.mode != MODE_STOP) &&
                    (s_next.mode != MODE_HW_STANDBY);
    s_next.pll_en = (s_next.mode == MODE_PLL_CLOCK) ||
                    (s_next.mode == MODE_PLL_SLEEP);
    s_next.main_div2 = (s_next.mode == MODE_MAIN_CLOCK) ||
                       (s_next.mode == MODE_MAIN_SLEEP);
    s_next.pll_ratio = {1'b0, s_next.cs} + 3'h1;
    s_next.low_power = (s_next.mode != MODE_PLL_CLOCK);
    s_next.pins_hiz = !s_next.pin_state &&
                      (s_next.mode == MODE_STOP ||
                       s_next.mode == MODE_TIMER ||
                       s_next.mode == MODE_HW_STANDBY);

    // A new event wins over a read-clear in the same cycle
    s_next.status = (s_reg.status & ~rd_clr) | events;
    s_next.irq = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.mode <= MODE_MAIN_CLOCK;
      s_reg.pin_state <= LPMC_RESET[PIN_STATE_POS];
      s_reg.cg <= LPMC_RESET[INTERMIT_SEL_LO+:2];
      s_reg.ws <= CSS_RESET[SETTLE_SEL_LO+:2];
      s_reg.main_clock_select <= CSS_RESET[MAIN_SEL_POS];
      s_reg.cs <= CSS_RESET[PLL_RATIO_LO+:2];
      s_reg.mask <= IRQ_MASK_RESET;
      s_reg.cpu_clk_en <= 1'b1;
      s_reg.periph_clk_en <= 1'b1;
      s_reg.tbt_run <= 1'b1;
      s_reg.osc_en <= 1'b1;
      s_reg.main_div2 <= 1'b1;
      s_reg.pll_ratio <= 3'h1;
      s_reg.low_power <= 1'b1;
    end else begin
      // Stop and standby only gate clocks; contents stay put
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cpu_clk_en = s_reg.cpu_clk_en;
  assign periph_clk_en = s_reg.periph_clk_en;
  assign tbt_run = s_reg.tbt_run;
  assign osc_en = s_reg.osc_en;
  assign pll_en = s_reg.pll_en;
  assign main_div2 = s_reg.main_div2;
  assign pll_ratio = s_reg.pll_ratio;
  assign low_power = s_reg.low_power;
  assign pins_hiz = s_reg.pins_hiz;
  assign sw_reset = s_reg.sw_reset;
  assign wdt_clk = tbt_carry;
  assign irq = s_reg.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic thr_h;
  assign thr_h = throttle;

  low_power_flag_a: assert property (
    low_power == (s_reg.mode != MODE_PLL_CLOCK))
    else $error("low_power disagrees with mode");
  stop_osc_off_a: assert property (
    (s_reg.mode == MODE_STOP || s_reg.mode == MODE_HW_STANDBY) |->
    !osc_en && !cpu_clk_en && !periph_clk_en)
    else $error("oscillator or clocks live in stop");
  sleep_cpu_gate_a: assert property (
    (s_reg.mode == MODE_PLL_SLEEP || s_reg.mode == MODE_MAIN_SLEEP) |->
    !cpu_clk_en && periph_clk_en && tbt_run)
    else $error("sleep gating wrong");
  timer_only_tbt_a: assert property (
    s_reg.mode == MODE_TIMER |-> tbt_run && !periph_clk_en && !cpu_clk_en)
    else $error("timer mode gating wrong");
  main_no_pll_a: assert property (
    (s_reg.mode == MODE_MAIN_CLOCK || s_reg.mode == MODE_MAIN_SLEEP) |->
    !pll_en && main_div2)
    else $error("PLL running in main mode");
  settle_hold_a: assert property (
    (s_reg.mode == MODE_STOP && wake_req && hw_standby_n) |=>
    (s_reg.mode == MODE_SETTLE && !cpu_clk_en) [*2])
    else $error("clock released before settling");
  pll_ratio_map_a: assert property (
    css_wr |=> pll_ratio == {1'b0, $past(hwdata[1:0])} + 3'h1)
    else $error("PLL ratio not decoded");
  throttle_gap_a: assert property (
    ($past(thr_h) && $past(thr_h, 2)) |-> !(cpu_clk_en && $past(cpu_clk_en)))
    else $error("CPU clock not throttled");
  periph_full_a: assert property (
    (thr_h && hw_standby_n && !lpmc_wr) |=> periph_clk_en)
    else $error("peripherals throttled");
  irq_level_a: assert property (
    (|(s_reg.status & s_reg.mask)) == irq)
    else $error("irq level wrong");

  stop_wake_c: cover property (
    s_reg.mode == MODE_SETTLE ##1 s_reg.mode == MODE_MAIN_CLOCK);
  sleep_entry_c: cover property (s_reg.mode == MODE_PLL_SLEEP);
  timer_entry_c: cover property (s_reg.mode == MODE_TIMER);
  throttle_c: cover property (thr_h [*4]);

endmodule
`default_nettype wire

// >>> logic/lpcc_pkg.sv
// Constants for the low-power and clock mode controller.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package lpcc_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [31:0] LPMC_IDX = 32'h0000_00a0;
  localparam logic [31:0] CSS_IDX = 32'h0000_00a1;
  localparam logic [31:0] IRQ_STATUS_IDX = 32'h0000_00a2;
  localparam logic [31:0] IRQ_MASK_IDX = 32'h0000_00a3;
  localparam logic [31:0] MODE_STATUS_IDX = 32'h0000_00a4;
  localparam logic [31:0] LPMC_ADDR = LPMC_IDX << 2;
  localparam logic [31:0] CSS_ADDR = CSS_IDX << 2;
  localparam logic [31:0] IRQ_STATUS_ADDR = IRQ_STATUS_IDX << 2;
  localparam logic [31:0] IRQ_MASK_ADDR = IRQ_MASK_IDX << 2;
  localparam logic [31:0] MODE_STATUS_ADDR = MODE_STATUS_IDX << 2;

  // Low-power mode control fields
  localparam logic [7:0] LPMC_RESET = 8'h18;
  localparam int STOP_ENTRY_POS = 7;
  localparam int SLEEP_ENTRY_POS = 6;
  localparam int PIN_STATE_POS = 5;
  localparam int SW_RESET_POS = 4;
  localparam int INTERMIT_SEL_LO = 1;

  // Clock source select fields
  localparam logic [7:0] CSS_RESET = 8'hfc;
  localparam int MAIN_IND_POS = 6;
  localparam int SETTLE_SEL_LO = 4;
  localparam int MAIN_SEL_POS = 2;
  localparam int PLL_RATIO_LO = 0;

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE_POS = 0;
  localparam int IRQ_TICK_POS = 1;
  localparam int IRQ_LP_POS = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // CPU throttle periods per intermittent select code
  localparam logic [4:0] INTERMIT_DIV1 = 5'h04;
  localparam logic [4:0] INTERMIT_DIV2 = 5'h08;
  localparam logic [4:0] INTERMIT_DIV3 = 5'h10;

  // Timebase and settle counters
  localparam int TBT_W = 18;
  localparam int TBT_TICK_W = 12;
  localparam int SETTLE_W = 18;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    MODE_PLL_CLOCK = 3'b000,
    MODE_PLL_SLEEP = 3'b001,
    MODE_TIMER = 3'b010,
    MODE_MAIN_CLOCK = 3'b011,
    MODE_MAIN_SLEEP = 3'b100,
    MODE_STOP = 3'b101,
    MODE_HW_STANDBY = 3'b110,
    MODE_SETTLE = 3'b111
  } mode_t;

endpackage

// >>> logic/timebase_counter.sv
// Free-running 18-bit timebase with carry and interval ticks.
// Assumes hclk is the main oscillator clock; run gates counting.
`timescale 1ns/1ns
`default_nettype none
module timebase_counter
  import lpcc_pkg::*;
(
  input wire logic hclk, // main oscillator clock
  input wire logic hresetn, // async reset, active low
  input wire logic run, // count enable
  output logic carry, // one-cycle pulse on full wrap
  output logic tick // one-cycle interval pulse
);

  typedef struct packed {
    logic [TBT_W-1:0] cnt;
    logic carry;
    logic tick;
  } tbt_state_t;

  tbt_state_t s_reg;
  tbt_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.carry = run && (&s_reg.cnt);
    s_next.tick = run && (&s_reg.cnt[TBT_TICK_W-1:0]);
    if (run) begin
      s_next.cnt = s_reg.cnt + 18'h00001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign carry = s_reg.carry;
  assign tick = s_reg.tick;

endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the low-power and clock mode controller.
// Assumes a single AHB-Lite master here and short settle counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  n_fail++; $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
  end end
module testbench;
  import lpcc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, wake_req, hw_standby_n, cpu_access;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, pll_ratio;
  logic hreadyout, hresp, cpu_clk_en, periph_clk_en, tbt_run, osc_en;
  logic pll_en, main_div2, low_power, pins_hiz, sw_reset, wdt_clk, irq;
  int n_fail = 0;
  int comparisons = 0;
  int n, k, n_swr = 0, n_wdt = 0;

  lp_clock_ctrl #(.SETTLE_CYC0(4), .SETTLE_CYC1(8), .SETTLE_CYC2(12),
    .SETTLE_CYC3(16)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req),
    .hw_standby_n(hw_standby_n), .cpu_access(cpu_access),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .tbt_run(tbt_run), .osc_en(osc_en), .pll_en(pll_en),
    .main_div2(main_div2), .pll_ratio(pll_ratio), .low_power(low_power),
    .pins_hiz(pins_hiz), .sw_reset(sw_reset), .wdt_clk(wdt_clk), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) if (sw_reset === 1'b1) n_swr++;
  always @(posedge hclk) if (wdt_clk === 1'b1) n_wdt++;

  task automatic wr(input logic [31:0] a, d,
    input logic [2:0] sz = HSIZE_WORD);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= 1'b1; hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
  endtask

  task automatic rdr(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= 1'b0;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    #1;
  endtask

  task automatic chk_rd(input string nm, input logic [31:0] a, ex);
    logic [31:0] d;
    rdr(a, d);
    `CHK(nm, ex, d)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // One wake pulse, then count cycles until the CPU clock returns
  task automatic wake(output int c);
    @(posedge hclk);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    #1;
    c = 0;
    while (cpu_clk_en !== 1'b1 && c < 300) begin
      @(posedge hclk);
      #1;
      c++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = HSIZE_WORD; hwdata = '0; wake_req = 1'b0; hw_standby_n = 1'b1;
    cpu_access = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk_rd("lpmc reset", LPMC_ADDR, 32'h18);
    chk_rd("css reset", CSS_ADDR, 32'hfc);
    chk_rd("mode reset", MODE_STATUS_ADDR, {29'h0, MODE_MAIN_CLOCK});
    `CHK("pll off", 1'b0, pll_en)
    `CHK("div2", 1'b1, main_div2)
    `CHK("lp main", 1'b1, low_power)
    chk_rd("unmapped", 32'h0000_0300, 32'h0);
    wr(CSS_ADDR, 32'h8b, 3'h0);
    chk_rd("byte write ignored", CSS_ADDR, 32'hfc);
    $display("test reset done");

    for (k = 0; k < 4; k++) begin
      wr(CSS_ADDR, 32'hb8 | k);
      // The mode follows main select one edge after the write lands
      @(posedge hclk);
      #1;
      `CHK("ratio", 3'(k + 1), pll_ratio)
      `CHK("pll on", 1'b1, pll_en)
      `CHK("no div2", 1'b0, main_div2)
      `CHK("lp pll", 1'b0, low_power)
      chk_rd("css pll", CSS_ADDR, 32'hb8 | k);
    end
    $display("test ratio done");

    wr(LPMC_ADDR, 32'h58);
    chk_rd("mode psleep", MODE_STATUS_ADDR, {29'h0, MODE_PLL_SLEEP});
    `CHK("sleep cpu", 1'b0, cpu_clk_en)
    `CHK("sleep periph", 1'b1, periph_clk_en)
    `CHK("sleep lp", 1'b1, low_power)
    `CHK("irq masked", 1'b0, irq)
    wake(n);
    chk_rd("mode back", MODE_STATUS_ADDR, {29'h0, MODE_PLL_CLOCK});
    wr(IRQ_MASK_ADDR, 32'h4);
    `CHK("irq on", 1'b1, irq)
    rdr(IRQ_STATUS_ADDR, rd);
    `CHK("lp event", 1'b1, rd[IRQ_LP_POS])
    `CHK("irq cleared", 1'b0, irq)
    $display("test sleep done");

    wr(CSS_ADDR, 32'h8c);
    wr(LPMC_ADDR, 32'h58);
    chk_rd("mode msleep", MODE_STATUS_ADDR, {29'h0, MODE_MAIN_SLEEP});
    `CHK("msleep pll", 1'b0, pll_en)
    `CHK("msleep periph", 1'b1, periph_clk_en)
    wake(n);
    wr(LPMC_ADDR, 32'hd8);
    chk_rd("mode timer", MODE_STATUS_ADDR, {29'h0, MODE_TIMER});
    `CHK("timer cpu", 1'b0, cpu_clk_en)
    `CHK("timer periph", 1'b0, periph_clk_en)
    `CHK("timer tbt", 1'b1, tbt_run)
    `CHK("timer hiz", 1'b1, pins_hiz)
    wake(n);
    `CHK("timer wake", 1'b1, cpu_clk_en)
    $display("test timer done");

    for (k = 0; k < 4; k++) begin
      wr(CSS_ADDR, 32'h8c | (k << 4));
      wr(LPMC_ADDR, 32'h98);
      `CHK("stop osc", 1'b0, osc_en)
      `CHK("stop periph", 1'b0, periph_clk_en)
      wake(n);
      n -= 4 * (k + 1);
      `CHK("settle len", 1'b1, n >= 0 && n <= 2)
      chk_rd("css kept", CSS_ADDR, 32'hcc | (k << 4));
      rdr(IRQ_STATUS_ADDR, rd);
      `CHK("wake event", 1'b1, rd[IRQ_WAKE_POS])
    end
    $display("test stop done");

    @(posedge hclk);
    hw_standby_n <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    `CHK("stby osc", 1'b0, osc_en)
    `CHK("stby cpu", 1'b0, cpu_clk_en)
    @(posedge hclk);
    hw_standby_n <= 1'b1;
    #1;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 300) begin
      @(posedge hclk);
      #1;
      n++;
    end
    `CHK("stby settle", 1'b1, n >= 16 && n <= 18)
    chk_rd("stby kept", CSS_ADDR, 32'hfc);
    $display("test standby done");

    for (k = 1; k < 4; k++) begin
      wr(LPMC_ADDR, 32'h18 | (k << 1));
      @(posedge hclk);
      cpu_access <= 1'b1;
      @(posedge hclk);
      #1;
      n = 0;
      rd = 0;
      repeat (32) begin
        @(posedge hclk);
        #1;
        n += (cpu_clk_en === 1'b1);
        rd += (periph_clk_en !== 1'b1);
      end
      `CHK("throttle", 32'(32 >> (k + 1)), 32'(n))
      `CHK("full periph", 32'h0, rd)
      @(posedge hclk);
      cpu_access <= 1'b0;
    end
    wr(LPMC_ADDR, 32'h18);
    $display("test throttle done");

    n = n_swr;
    wr(LPMC_ADDR, 32'h08);
    repeat (3) @(posedge hclk);
    `CHK("sw reset pulse", 32'(n + 1), 32'(n_swr))
    $display("test swreset done");

    rdr(IRQ_STATUS_ADDR, rd);
    wr(IRQ_MASK_ADDR, 32'h2);
    n = 0;
    while (irq !== 1'b1 && n < 4200) begin
      @(posedge hclk);
      #1;
      n++;
    end
    `CHK("tick within", 1'b1, n <= 4097)
    rdr(IRQ_STATUS_ADDR, rd);
    `CHK("tick event", 1'b1, rd[IRQ_TICK_POS])
    // A carry needs a full 18-bit wrap, far longer than this run
    `CHK("no early carry", 32'h0, 32'(n_wdt))
    $display("test timebase done");
    finish_test();
  end
endmodule
`default_nettype wire
